/* hw/fsr_bus_cycle.sv */
`timescale 1ns/100ps
`default_nettype none
// One asynchronous write or read cycle on the flash bus
module fsr_bus_cycle
	import fsr_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic is_read,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] dq_in,
	output logic [ADDR_W-1:0] flash_addr,
	output logic [7:0] dq_out,
	output logic dq_oe,
	output logic we_n,
	output logic oe_n,
	output logic ce_n,
	output logic done,
	output logic [7:0] rdata
);
	typedef struct packed {
		logic busy;
		logic rd;
		logic [CYC_W-1:0] cnt;
		logic [ADDR_W-1:0] a;
		logic [7:0] d;
		logic oe;
		logic we_n;
		logic oe_n;
		logic ce_n;
		logic done;
		logic [7:0] r;
	} fsr_bc_t;
	fsr_bc_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		if (!s_q.busy) begin
			if (start) begin
				s_d.busy = 1'b1;
				s_d.rd = is_read;
				s_d.a = addr;
				s_d.d = wdata;
				s_d.ce_n = 1'b0;
				s_d.we_n = is_read;
				s_d.oe_n = !is_read;
				s_d.oe = !is_read;
				s_d.cnt = is_read ? CYC_W'(RD_WAIT_CYC) : CYC_W'(WE_LOW_CYC);
			end
		end else if (s_q.cnt != '0) begin
			s_d.cnt = s_q.cnt - 1'b1;
		end else begin
			// Rising edge of write enable latches the command
			if (s_q.rd)
				s_d.r = dq_in;
			s_d.busy = 1'b0;
			s_d.we_n = 1'b1;
			s_d.oe_n = 1'b1;
			s_d.ce_n = 1'b1;
			s_d.oe = 1'b0;
			s_d.done = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s_q <= '0;
			s_q.we_n <= 1'b1;
			s_q.oe_n <= 1'b1;
			s_q.ce_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign flash_addr = s_q.a;
	assign dq_out = s_q.d;
	assign dq_oe = s_q.oe;
	assign we_n = s_q.we_n;
	assign oe_n = s_q.oe_n;
	assign ce_n = s_q.ce_n;
	assign done = s_q.done;
	assign rdata = s_q.r;
endmodule : fsr_bus_cycle
`default_nettype wire

/* hw/fsr_host_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Host refuses every retry but read array until status is cleared
// - Late suspend gives array; read status
// - Host holds reset, write protect steady
// - Host adds no spacing between resume and suspend
// - Program suspended shows ready, suspended
// - Resume program before resuming erase
module fsr_host_ctrl
	import fsr_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic req_valid,
	input wire fsr_op_t req_op,
	input wire logic [ADDR_W-1:0] req_addr,
	output logic req_ready,
	output logic resp_valid,
	output logic [7:0] resp_status,
	output logic resp_suspended,
	output logic resp_error,
	output logic resp_refused,
	output logic [ADDR_W-1:0] flash_addr,
	output logic [7:0] flash_dq_out,
	output logic flash_dq_oe,
	input wire logic [7:0] flash_dq_in,
	output logic flash_we_n,
	output logic flash_oe_n,
	output logic flash_ce_n,
	output logic flash_rst_n,
	output logic flash_wp_n
);
	typedef enum {ST_IDLE, ST_CMD, ST_RDSR_CMD, ST_RDSR, ST_POLL, ST_DONE} fsr_st_t;
	typedef struct packed {
		fsr_st_t st;
		fsr_op_t op;
		logic [ADDR_W-1:0] a;
		logic [7:0] sr;
		logic err_seen;
		logic erase_susp;
		logic [PART_W-1:0] erase_part;
		logic prog_susp;
		logic [PART_W-1:0] prog_part;
		logic rsp_v;
		logic rsp_susp;
		logic rsp_err;
		logic rsp_ref;
		logic go;
		logic rd;
		logic [7:0] wd;
		logic rdy;
		logic rst_n;
		logic wp_n;
	} fsr_hs_t;
	fsr_hs_t s_q, s_d;
	logic bc_done;
	logic [7:0] bc_rdata;

	function automatic logic [PART_W-1:0] part_of(input logic [ADDR_W-1:0] a);
		part_of = a[ADDR_W-1 -: PART_W];
	endfunction : part_of

	function automatic logic any_err(input logic [7:0] sr);
		any_err = sr[SR_ERASE_ERR] | sr[SR_PROG_ERR] | sr[SR_VPP_ERR] | sr[SR_PROTECT];
	endfunction : any_err

	// Only read array, clear status, suspend and resume codes
	function automatic logic [7:0] op_code(input fsr_op_t op);
		unique case (op)
			FSR_OP_SUSPEND_ERASE, FSR_OP_SUSPEND_PROG: op_code = CMD_SUSPEND;
			FSR_OP_RESUME_ERASE, FSR_OP_RESUME_PROG: op_code = CMD_RESUME;
			FSR_OP_CLEAR_STATUS: op_code = CMD_CLEAR_STATUS;
			default: op_code = CMD_READ_ARRAY;
		endcase
	endfunction : op_code

	always_comb begin
		s_d = s_q;
		s_d.rsp_v = 1'b0;
		s_d.go = 1'b0;
		unique case (s_q.st)
			ST_IDLE: begin
				if (req_valid) begin
					s_d.op = req_op;
					s_d.a = req_addr;
					s_d.rsp_ref = 1'b0;
					// Retry blocked until errors cleared
					if (s_q.err_seen && req_op != FSR_OP_CLEAR_STATUS && req_op != FSR_OP_READ_ARRAY) begin
						s_d.rsp_ref = 1'b1;
						s_d.st = ST_DONE;
					// Erase resume held back while a program is suspended
					end else if (req_op == FSR_OP_RESUME_ERASE && s_q.prog_susp) begin
						s_d.rsp_ref = 1'b1;
						s_d.st = ST_DONE;
					end else begin
						s_d.go = 1'b1;
						s_d.rd = 1'b0;
						s_d.wd = op_code(req_op);
						s_d.st = ST_CMD;
					end
				end
			end
			ST_CMD: begin
				if (bc_done) begin
					if (s_q.op == FSR_OP_READ_ARRAY) begin
						s_d.st = ST_DONE;
					end else begin
						// Suspend may land after completion: force status mode
						s_d.go = 1'b1;
						s_d.wd = CMD_READ_STATUS;
						s_d.st = ST_RDSR_CMD;
					end
				end
			end
			ST_RDSR_CMD: begin
				if (bc_done) begin
					s_d.go = 1'b1;
					s_d.rd = 1'b1;
					s_d.st = ST_RDSR;
				end
			end
			ST_RDSR: begin
				if (bc_done) begin
					s_d.sr = bc_rdata;
					s_d.st = ST_POLL;
				end
			end
			ST_POLL: begin
				// Busy until ready bit rises
				// Resume and confirm leave ready low: no poll
				if (!s_q.sr[SR_READY] && s_q.op != FSR_OP_RESUME_ERASE && s_q.op != FSR_OP_RESUME_PROG) begin
					s_d.go = 1'b1;
					s_d.st = ST_RDSR;
				end else begin
					// Sticky error bits decide recovery
					s_d.err_seen = any_err(s_q.sr) && s_q.op != FSR_OP_CLEAR_STATUS;
					s_d.rsp_susp = 1'b0;
					unique case (s_q.op)
						FSR_OP_SUSPEND_ERASE: begin
							// Suspended only when both bits set
							s_d.rsp_susp = s_q.sr[SR_ERASE_SUSP];
							s_d.erase_susp = s_q.sr[SR_ERASE_SUSP];
							s_d.erase_part = part_of(s_q.a);
						end
						FSR_OP_SUSPEND_PROG: begin
							s_d.rsp_susp = s_q.sr[SR_PROG_SUSP];
							s_d.prog_susp = s_q.sr[SR_PROG_SUSP];
							s_d.prog_part = part_of(s_q.a);
						end
						FSR_OP_RESUME_PROG: s_d.prog_susp = 1'b0;
						FSR_OP_RESUME_ERASE: s_d.erase_susp = 1'b0;
						default: s_d.rsp_susp = 1'b0;
					endcase
					s_d.st = ST_DONE;
				end
			end
			ST_DONE: begin
				s_d.rsp_v = 1'b1;
				s_d.rsp_err = s_q.err_seen;
				s_d.st = ST_IDLE;
			end
			default: s_d.st = ST_IDLE;
		endcase
		// Ready flag registered from the next state
		s_d.rdy = (s_d.st == ST_IDLE);
		// Reset and write protect held steady through suspend
		s_d.rst_n = 1'b1;
		s_d.wp_n = 1'b1;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s_q <= '0;
			s_q.st <= ST_IDLE;
			s_q.rdy <= 1'b1;
			s_q.rst_n <= 1'b1;
			s_q.wp_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	fsr_bus_cycle u_cycle (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.start(s_q.go),
		.is_read(s_q.rd),
		.addr(s_q.a),
		.wdata(s_q.wd),
		.dq_in(flash_dq_in),
		.flash_addr(flash_addr),
		.dq_out(flash_dq_out),
		.dq_oe(flash_dq_oe),
		.we_n(flash_we_n),
		.oe_n(flash_oe_n),
		.ce_n(flash_ce_n),
		.done(bc_done),
		.rdata(bc_rdata)
	);

	assign req_ready = s_q.rdy;
	assign resp_valid = s_q.rsp_v;
	assign resp_status = s_q.sr;
	assign resp_suspended = s_q.rsp_susp;
	assign resp_error = s_q.rsp_err;
	assign resp_refused = s_q.rsp_ref;
	assign flash_rst_n = s_q.rst_n;
	assign flash_wp_n = s_q.wp_n;

	a_resume_order: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(s_q.st == ST_IDLE && req_valid && req_op == FSR_OP_RESUME_ERASE && s_q.prog_susp)
		|=> s_q.st == ST_DONE && s_q.rsp_ref) else $error("erase resume issued over suspended program");
	a_retry_blocked: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(s_q.st == ST_IDLE && req_valid && s_q.err_seen && req_op == FSR_OP_SUSPEND_PROG)
		|=> s_q.rsp_ref) else $error("command sent with errors pending");
	a_status_after: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(s_q.st == ST_CMD && bc_done && s_q.op == FSR_OP_SUSPEND_ERASE)
		|=> s_q.go && s_q.wd == CMD_READ_STATUS) else $error("no read status after suspend");
	a_poll_busy: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(s_q.st == ST_POLL && !s_q.sr[SR_READY] && s_q.op == FSR_OP_SUSPEND_PROG)
		|=> s_q.st == ST_RDSR) else $error("busy status not polled");
	a_resume_clears: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(s_q.st == ST_POLL && s_q.op == FSR_OP_RESUME_ERASE)
		|=> !s_q.erase_susp && s_q.st == ST_DONE) else $error("erase resume left suspend mark set");
	a_refused_quiet: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(s_q.st == ST_DONE && s_q.rsp_ref)
		|-> !s_q.go && flash_ce_n) else $error("refused request reached the bus");
	a_suspend_mark: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(s_q.st == ST_POLL && s_q.op == FSR_OP_SUSPEND_ERASE && s_q.sr[SR_READY])
		|=> s_q.erase_susp == $past(s_q.sr[SR_ERASE_SUSP]) && s_q.rsp_susp == $past(s_q.sr[SR_ERASE_SUSP]))
		else $error("erase suspend mark differs from status");
endmodule : fsr_host_ctrl
`default_nettype wire

/* shared/fsr_pkg.sv */
package fsr_pkg;
	localparam logic [7:0] CMD_SUSPEND = 8'hb0;
	localparam logic [7:0] CMD_RESUME = 8'hd0;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
	localparam int SR_READY = 7;
	localparam int SR_ERASE_SUSP = 6;
	localparam int SR_ERASE_ERR = 5;
	localparam int SR_PROG_ERR = 4;
	localparam int SR_VPP_ERR = 3;
	localparam int SR_PROG_SUSP = 2;
	localparam int SR_PROTECT = 1;
	localparam int PART_W = 2;
	localparam int ADDR_W = 22;
	// Bus write and read strobe timing, cycles at 50 MHz
	localparam int WE_LOW_CYC = 4;
	localparam int RD_WAIT_CYC = 5;
	localparam int CYC_W = 4;
	typedef enum logic [2:0] {
		FSR_OP_SUSPEND_ERASE,
		FSR_OP_SUSPEND_PROG,
		FSR_OP_RESUME_ERASE,
		FSR_OP_RESUME_PROG,
		FSR_OP_CLEAR_STATUS,
		FSR_OP_READ_ARRAY
	} fsr_op_t;
endpackage : fsr_pkg

/* sim/fsr_flash_model.sv */
`timescale 1ns/100ps
`default_nettype none
module fsr_flash_model
	import fsr_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [ADDR_W-1:0] flash_addr,
	input wire logic [7:0] dq_out,
	input wire logic dq_oe,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic ce_n,
	output logic [7:0] dq_in,
	input wire logic [3:0] ctl,
	input wire logic [1:0] part,
	input wire logic [2:0] lat
);
	logic we_q, erun, prun, esus, psus;
	logic [1:0] ep, pp, cp;
	logic [3:0] smode;
	logic [4:0] wc;
	logic [7:0] cmd, err, last, sr;
	wire logic rd = !ce_n && !oe_n;
	assign sr = {~(erun | prun), esus, err[5:3], psus, err[1], 1'b0};
	// Released bus shows the inverse of the last byte
	assign dq_in = rd ? (smode[flash_addr[ADDR_W-1 -: PART_W]] ? sr : flash_addr[7:0]) : ~last;
	always @(posedge clk_sys) begin
		we_q <= we_n;
		if (rd) last <= dq_in;
		if (!we_n && !ce_n && dq_oe) begin
			cmd <= dq_out;
			cp <= flash_addr[ADDR_W-1 -: PART_W];
		end
		if (ctl[0]) begin erun <= 1'b1; ep <= part; end
		if (ctl[1]) begin prun <= 1'b1; pp <= part; end
		if (ctl[2]) begin erun <= 1'b0; prun <= 1'b0; end
		if (ctl[3]) err[5:4] <= 2'b11;
		if (wc != 0) wc <= wc - 5'h01;
		if (wc == 1 && prun) begin prun <= 1'b0; psus <= 1'b1; end
		if (wc == 1 && !prun) begin erun <= 1'b0; esus <= 1'b1; end
		if (we_n && !we_q) case (cmd)
			CMD_SUSPEND: begin
				// Nothing running: back to array data
				smode[cp] <= (prun && cp == pp) || (erun && cp == ep);
				// Long latencies make the host poll a busy status
				if ((prun && cp == pp) || (erun && cp == ep)) wc <= {lat, 2'h3};
			end
			CMD_READ_STATUS: smode[cp] <= 1'b1;
			CMD_CLEAR_STATUS: err <= 8'h00;
			CMD_READ_ARRAY: smode[cp] <= 1'b0;
			CMD_RESUME: if (psus && cp == pp) begin
				psus <= 1'b0; prun <= 1'b1; smode[cp] <= 1'b1;
			end else if (esus && !psus && !prun && cp == ep) begin
				esus <= 1'b0; erun <= 1'b1; smode[cp] <= 1'b1;
			end else smode[cp] <= 1'b0;
			default: ;
		endcase
		if (sys_rst) begin
			{erun, prun, esus, psus, wc, smode, err, last} <= '0;
			we_q <= 1'b1;
		end
	end
endmodule : fsr_flash_model
`default_nettype wire

/* sim/fsr_host_ctrl_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module fsr_host_ctrl_tb
	import fsr_pkg::*;
;
	logic clk_sys, sys_rst, req_valid, req_ready, resp_valid, resp_suspended, resp_error, resp_refused;
	logic dq_oe, we_n, oe_n, ce_n, flash_rst_n, flash_wp_n;
	fsr_op_t req_op;
	logic [ADDR_W-1:0] req_addr, flash_addr;
	logic [7:0] resp_status, dq_out, dq_in;
	logic [3:0] ctl;
	logic [1:0] part, p;
	logic [2:0] lat;
	logic [31:0] seed;
	int errors, checked;
	fsr_host_ctrl fsr_host_ctrl_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .req_valid(req_valid),
		.req_op(req_op), .req_addr(req_addr), .req_ready(req_ready), .resp_valid(resp_valid),
		.resp_status(resp_status), .resp_suspended(resp_suspended), .resp_error(resp_error),
		.resp_refused(resp_refused), .flash_addr(flash_addr), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe),
		.flash_dq_in(dq_in), .flash_we_n(we_n), .flash_oe_n(oe_n), .flash_ce_n(ce_n),
		.flash_rst_n(flash_rst_n), .flash_wp_n(flash_wp_n));
	fsr_flash_model fsr_flash_model_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .flash_addr(flash_addr),
		.dq_out(dq_out), .dq_oe(dq_oe), .we_n(we_n), .oe_n(oe_n), .ce_n(ce_n), .dq_in(dq_in),
		.ctl(ctl), .part(part), .lat(lat));
	always #10 clk_sys = ~clk_sys;
	function logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	function logic [7:0] exp_st(input logic rdy, input logic es, input logic ps, input logic er);
		return {rdy, es, er, er, 1'b0, ps, 2'b00};
	endfunction : exp_st
	task end_sim;
		$display("errors=%0d checked=%0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim
	task chk8(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin errors++; $display("BAD %0t status %h exp %h", $time, got, exp); end
	endtask : chk8
	task chk1(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin errors++; $display("BAD %0t flag %b exp %b", $time, got, exp); end
	endtask : chk1
	// Model control pulse, random suspend latency
	task kick(input logic [3:0] m, input logic [1:0] q);
		@(posedge clk_sys);
		ctl <= m;
		part <= q;
		lat <= seed[2:0];
		@(posedge clk_sys);
		ctl <= 4'h0;
	endtask : kick
	task req(input fsr_op_t op, input logic [1:0] q);
		int n;
		n = 0;
		seed = xs(seed);
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req_op <= op;
		req_addr <= {q, seed[19:0]};
		@(negedge clk_sys);
		while (req_ready !== 1'b1 && n < 9) begin @(negedge clk_sys); n++; end
		if (n >= 9) begin errors++; $display("BAD %0t not ready", $time); end_sim(); end
		@(posedge clk_sys);
		req_valid <= 1'b0;
		while (resp_valid !== 1'b1 && n < 2000) begin @(negedge clk_sys); n++; end
		if (n >= 2000) begin errors++; $display("BAD %0t no response", $time); end_sim(); end
	endtask : req
	initial begin
		{clk_sys, req_valid, ctl, part, lat, errors, checked} = '0;
		sys_rst = 1'b1;
		req_op = FSR_OP_READ_ARRAY;
		req_addr = '0;
		seed = 32'h22;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			seed = xs(seed);
			p = seed[31:30];
			kick(4'h1, p);
			req(FSR_OP_SUSPEND_ERASE, p);
			chk8(resp_status, exp_st(1, 1, 0, 0));
			chk1(resp_suspended, 1'b1);
			chk1(flash_rst_n & flash_wp_n, 1'b1);
			kick(4'h2, p + 2'd1);
			req(FSR_OP_SUSPEND_PROG, p + 2'd1);
			chk8(resp_status, exp_st(1, 1, 1, 0));
			req(FSR_OP_RESUME_ERASE, p);
			chk1(resp_refused, 1'b1);
			req(FSR_OP_RESUME_PROG, p + 2'd1);
			chk8(resp_status, exp_st(0, 1, 0, 0));
			kick(4'h4, p);
			req(FSR_OP_RESUME_ERASE, p);
			chk8(resp_status, exp_st(0, 0, 0, 0));
			kick(4'h4, p);
			req(FSR_OP_SUSPEND_ERASE, p);
			chk8(resp_status, exp_st(1, 0, 0, 0));
			chk1(resp_suspended, 1'b0);
		end
		kick(4'h8, 2'd0);
		req(FSR_OP_SUSPEND_ERASE, 2'd0);
		chk8(resp_status, exp_st(1, 0, 0, 1));
		chk1(resp_error, 1'b1);
		req(FSR_OP_SUSPEND_PROG, 2'd0);
		chk1(resp_refused, 1'b1);
		req(FSR_OP_READ_ARRAY, 2'd0);
		chk1(resp_refused, 1'b0);
		req(FSR_OP_CLEAR_STATUS, 2'd0);
		chk1(resp_refused, 1'b0);
		req(FSR_OP_SUSPEND_ERASE, 2'd1);
		chk8(resp_status, exp_st(1, 0, 0, 0));
		chk1(resp_error, 1'b0);
		end_sim();
	end
endmodule : fsr_host_ctrl_tb
`default_nettype wire
